// ---- hdl/sct_pkg.sv ----
/*
  Constants shared by the instruction timing decoder.
  Assumes an 8-bit opcode from the fetch path and one core clock per cycle.
*/
package sct_pkg;

  ////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int OPC_W = 8;
  localparam int CYC_W = 5;
  localparam int WAIT_W = 4;
  localparam int BYTES_W = 2;

  ////////////////////////////////////////////////////////////////////////
  // Clock: one instruction cycle is one core clock period
  localparam int CLK_PERIOD_PS = 5000;
  localparam int CLKS_PER_CYCLE = 1;

  ////////////////////////////////////////////////////////////////////////
  // Logical operation groups, by high nibble and low nibble
  localparam logic [3:0] NIB_OR = 4'h4;
  localparam logic [3:0] NIB_AND = 4'h5;
  localparam logic [3:0] NIB_XOR = 4'h6;
  localparam logic [3:0] LO_DIR_ACC = 4'h2;
  localparam logic [3:0] LO_DIR_IMM = 4'h3;
  localparam logic [3:0] LO_ACC_IMM = 4'h4;
  localparam logic [3:0] LO_ACC_DIR = 4'h5;
  localparam logic [2:0] LO_IND_TOP3 = 3'h3;

  ////////////////////////////////////////////////////////////////////////
  // Accumulator, carry and no-operation opcodes
  localparam logic [7:0] OP_NOP = 8'h00;
  localparam logic [7:0] OP_CLR_ACC = 8'hE4;
  localparam logic [7:0] OP_CPL_ACC = 8'hF4;
  localparam logic [7:0] OP_SWAP_ACC = 8'hC4;
  localparam logic [7:0] OP_ROT_L = 8'h23;
  localparam logic [7:0] OP_ROT_LC = 8'h33;
  localparam logic [7:0] OP_ROT_R = 8'h03;
  localparam logic [7:0] OP_ROT_RC = 8'h13;
  localparam logic [7:0] OP_CLR_CY = 8'hC3;
  localparam logic [7:0] OP_SET_CY = 8'hD3;
  localparam logic [7:0] OP_CPL_CY = 8'hB3;

  ////////////////////////////////////////////////////////////////////////
  // Addressed bit opcodes
  localparam logic [7:0] OP_CLR_BIT = 8'hC2;
  localparam logic [7:0] OP_SET_BIT = 8'hD2;
  localparam logic [7:0] OP_CPL_BIT = 8'hB2;
  localparam logic [7:0] OP_AND_CY_BIT = 8'h82;
  localparam logic [7:0] OP_AND_CY_NBIT = 8'hB0;
  localparam logic [7:0] OP_OR_CY_BIT = 8'h72;
  localparam logic [7:0] OP_OR_CY_NBIT = 8'hA0;
  localparam logic [7:0] OP_BIT_TO_CY = 8'hA2;
  localparam logic [7:0] OP_CY_TO_BIT = 8'h92;

  ////////////////////////////////////////////////////////////////////////
  // Branch opcodes
  localparam logic [7:0] OP_JUMP_ACC_PTR = 8'h73;
  localparam logic [7:0] OP_RETURN = 8'h22;
  localparam logic [7:0] OP_IRQ_RETURN = 8'h32;
  localparam logic [3:0] LO_ABS_BRANCH = 4'h1;
  localparam logic [7:0] OP_SHORT_JUMP = 8'h80;
  localparam logic [7:0] OP_JUMP_CY = 8'h40;
  localparam logic [7:0] OP_JUMP_NCY = 8'h50;
  localparam logic [7:0] OP_JUMP_ZERO = 8'h60;
  localparam logic [7:0] OP_JUMP_NZERO = 8'h70;
  localparam logic [4:0] TOP5_DEC_REG_JUMP = 5'h1B;
  localparam logic [7:0] OP_LONG_JUMP = 8'h02;
  localparam logic [7:0] OP_LONG_CALL = 8'h12;
  localparam logic [7:0] OP_JUMP_BIT = 8'h20;
  localparam logic [7:0] OP_JUMP_NBIT = 8'h30;
  localparam logic [7:0] OP_JUMP_BIT_CLR = 8'h10;
  localparam logic [7:0] OP_CMP_ACC_DIR = 8'hB5;
  localparam logic [7:0] OP_CMP_ACC_IMM = 8'hB4;
  localparam logic [4:0] TOP5_CMP_REG = 5'h17;
  localparam logic [6:0] TOP7_CMP_IND = 7'h5B;
  localparam logic [7:0] OP_DEC_DIR_JUMP = 8'hD5;

  ////////////////////////////////////////////////////////////////////////
  // External data moves: top three bits set, low nibble 0, 2 or 3
  localparam logic [2:0] TOP3_EXT_MOVE = 3'h7;
  localparam logic [3:0] LO_EXT_A = 4'h0;
  localparam logic [3:0] LO_EXT_B = 4'h2;
  localparam logic [3:0] LO_EXT_C = 4'h3;

  ////////////////////////////////////////////////////////////////////////
  // Cycle counts and lengths
  localparam logic [CYC_W-1:0] CYC_ONE = 5'h01;
  localparam logic [CYC_W-1:0] CYC_TWO = 5'h02;
  localparam logic [CYC_W-1:0] CYC_THREE = 5'h03;
  localparam logic [CYC_W-1:0] CYC_FOUR = 5'h04;
  localparam logic [CYC_W-1:0] CYC_EXT_BASE = 5'h04;
  localparam logic [CYC_W-1:0] CYC_IRQ_CALL = 5'h03;
  localparam logic [BYTES_W-1:0] LEN_ONE = 2'h1;
  localparam logic [BYTES_W-1:0] LEN_TWO = 2'h2;
  localparam logic [BYTES_W-1:0] LEN_THREE = 2'h3;

  ////////////////////////////////////////////////////////////////////////
  // Reset values
  localparam logic [CYC_W-1:0] RST_CYC = 5'h00;
  localparam logic [BYTES_W-1:0] RST_LEN = 2'h0;

endpackage

// ---- hdl/sct_hold_reg.sv ----
/*
  Holding register: captures a value when load is high, else keeps it.
  Assumes a synchronous load from logic on the same clock.
*/
`timescale 1ns/100ps
module sct_hold_reg #(
  parameter int W = 1
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  // Reset to zero; the owner maps zero to its idle meaning
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else if (load) begin
      q <= d;
    end
  end

endmodule

// ---- hdl/sct_cycle_counter.sv ----
/*
  Down counter of remaining instruction cycles, one step per clock.
  Assumes load and value come from logic on the same clock.
*/
`timescale 1ns/100ps
module sct_cycle_counter #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic load,
  input wire logic [W-1:0] load_value,
  output logic [W-1:0] count_d,
  output logic [W-1:0] count_q
);

  // Load wins; otherwise step down and rest at zero
  assign count_d = load ? load_value : ((count_q != '0) ? count_q - W'(1) : count_q);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      count_q <= '0;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

// ---- hdl/sct_instr_timing.sv ----
/*
  Instruction length and cycle-count decoder with execute hold-off.
  Assumes the fetch path offers one opcode at a time with issue_valid and
  keeps it until issue_ready_q accepts it; wait setting comes from core logic.
*/
`timescale 1ns/100ps
module sct_instr_timing (
  input wire logic clk,
  input wire logic rstn,
  input wire logic issue_valid,
  input wire logic [sct_pkg::OPC_W-1:0] issue_opcode,
  input wire logic issue_from_irq,
  input wire logic [sct_pkg::WAIT_W-1:0] ext_wait_setting,
  output logic issue_ready_q,
  output logic [sct_pkg::BYTES_W-1:0] cur_bytes_q,
  output logic [sct_pkg::CYC_W-1:0] cur_cycles_q,
  output logic cur_ext_move_q,
  output logic cur_irq_call_q,
  output logic decode_miss_q
);

  ////////////////////////////////////////////////////////////////////////
  // Opcode fields
  logic [7:0] op;
  logic [3:0] hi;
  logic [3:0] lo;
  assign op = issue_opcode;
  assign hi = op[7:4];
  assign lo = op[3:0];

  ////////////////////////////////////////////////////////////////////////
  // Logical group: or, and, xor share one layout by high nibble
  logic logic_grp;
  logic lg_reg;
  logic lg_ind;
  logic lg_two;
  logic lg_three;
  assign logic_grp = (hi == sct_pkg::NIB_OR) || (hi == sct_pkg::NIB_AND) || (hi == sct_pkg::NIB_XOR);
  assign lg_reg = logic_grp && op[3];
  assign lg_ind = logic_grp && (op[3:1] == sct_pkg::LO_IND_TOP3);
  assign lg_two = logic_grp && ((lo == sct_pkg::LO_DIR_ACC) || (lo == sct_pkg::LO_ACC_IMM)
                  || (lo == sct_pkg::LO_ACC_DIR));
  assign lg_three = logic_grp && (lo == sct_pkg::LO_DIR_IMM);

  ////////////////////////////////////////////////////////////////////////
  // Accumulator and carry single-cycle group
  logic acc_op;
  assign acc_op = (op == sct_pkg::OP_NOP) || (op == sct_pkg::OP_CLR_ACC) || (op == sct_pkg::OP_CPL_ACC)
                  || (op == sct_pkg::OP_SWAP_ACC) || (op == sct_pkg::OP_ROT_L) || (op == sct_pkg::OP_ROT_LC)
                  || (op == sct_pkg::OP_ROT_R) || (op == sct_pkg::OP_ROT_RC) || (op == sct_pkg::OP_CLR_CY)
                  || (op == sct_pkg::OP_SET_CY) || (op == sct_pkg::OP_CPL_CY);

  ////////////////////////////////////////////////////////////////////////
  // Addressed bit group
  logic bit_op;
  logic bit_move;
  assign bit_op = (op == sct_pkg::OP_CLR_BIT) || (op == sct_pkg::OP_SET_BIT) || (op == sct_pkg::OP_CPL_BIT)
                  || (op == sct_pkg::OP_AND_CY_BIT) || (op == sct_pkg::OP_AND_CY_NBIT)
                  || (op == sct_pkg::OP_OR_CY_BIT) || (op == sct_pkg::OP_OR_CY_NBIT);
  assign bit_move = (op == sct_pkg::OP_BIT_TO_CY) || (op == sct_pkg::OP_CY_TO_BIT);

  ////////////////////////////////////////////////////////////////////////
  // Branch groups
  logic br_ptr;
  logic br_return;
  logic br_abs;
  logic br_rel;
  logic br_long;
  logic br_call;
  logic br_bit;
  logic br_cmp;
  logic br_dec_dir;
  assign br_ptr = (op == sct_pkg::OP_JUMP_ACC_PTR);
  assign br_return = (op == sct_pkg::OP_RETURN) || (op == sct_pkg::OP_IRQ_RETURN);
  // Absolute forms sit in every row; low nibble alone marks them
  assign br_abs = (lo == sct_pkg::LO_ABS_BRANCH) || (op == sct_pkg::OP_SHORT_JUMP);
  assign br_rel = (op == sct_pkg::OP_JUMP_CY) || (op == sct_pkg::OP_JUMP_NCY) || (op == sct_pkg::OP_JUMP_ZERO)
                  || (op == sct_pkg::OP_JUMP_NZERO) || (op[7:3] == sct_pkg::TOP5_DEC_REG_JUMP);
  assign br_call = (op == sct_pkg::OP_LONG_CALL);
  assign br_long = (op == sct_pkg::OP_LONG_JUMP) || br_call;
  assign br_bit = (op == sct_pkg::OP_JUMP_BIT) || (op == sct_pkg::OP_JUMP_NBIT)
                  || (op == sct_pkg::OP_JUMP_BIT_CLR);
  assign br_cmp = (op == sct_pkg::OP_CMP_ACC_DIR) || (op == sct_pkg::OP_CMP_ACC_IMM)
                  || (op[7:3] == sct_pkg::TOP5_CMP_REG) || (op[7:1] == sct_pkg::TOP7_CMP_IND);
  assign br_dec_dir = (op == sct_pkg::OP_DEC_DIR_JUMP);

  ////////////////////////////////////////////////////////////////////////
  // External moves and interrupt-entry call
  logic ext_move;
  logic irq_call;
  assign ext_move = (op[7:5] == sct_pkg::TOP3_EXT_MOVE) && ((lo == sct_pkg::LO_EXT_A)
                    || (lo == sct_pkg::LO_EXT_B) || (lo == sct_pkg::LO_EXT_C));
  // Only the long call opcode may be shortened; the flag is ignored otherwise
  assign irq_call = br_call && issue_from_irq;

  ////////////////////////////////////////////////////////////////////////
  // Length selection
  logic is_len1;
  logic is_len2;
  logic is_len3;
  logic dec_hit;
  logic [sct_pkg::BYTES_W-1:0] dec_bytes;
  assign is_len1 = lg_reg || lg_ind || acc_op || br_ptr || br_return || ext_move;
  assign is_len2 = lg_two || bit_op || bit_move || br_abs || br_rel;
  assign is_len3 = lg_three || br_long || br_bit || br_cmp || br_dec_dir;
  assign dec_hit = is_len1 || is_len2 || is_len3;
  // Unlisted opcodes fall back to one byte so the fetch path keeps moving
  assign dec_bytes = is_len3 ? sct_pkg::LEN_THREE : (is_len2 ? sct_pkg::LEN_TWO : sct_pkg::LEN_ONE);

  ////////////////////////////////////////////////////////////////////////
  // Cycle selection; external moves stretch by the wait setting
  logic cyc4;
  logic cyc3;
  logic cyc2;
  logic [sct_pkg::CYC_W-1:0] ext_cycles;
  logic [sct_pkg::CYC_W-1:0] dec_cycles;
  assign cyc4 = (br_long && !irq_call) || br_return || br_bit || br_cmp || br_dec_dir;
  assign cyc3 = lg_three || br_ptr || br_abs || br_rel || irq_call;
  assign cyc2 = lg_ind || lg_two || bit_op || bit_move;
  assign ext_cycles = sct_pkg::CYC_EXT_BASE + sct_pkg::CYC_W'(ext_wait_setting);
  assign dec_cycles = ext_move ? ext_cycles :
                      irq_call ? sct_pkg::CYC_IRQ_CALL :
                      cyc4 ? sct_pkg::CYC_FOUR :
                      cyc3 ? sct_pkg::CYC_THREE :
                      cyc2 ? sct_pkg::CYC_TWO : sct_pkg::CYC_ONE;

  ////////////////////////////////////////////////////////////////////////
  // Acceptance and remaining-cycle counter
  logic accept;
  logic [sct_pkg::CYC_W-1:0] remain_d;
  logic [sct_pkg::CYC_W-1:0] remain_q;
  logic [sct_pkg::CYC_W-1:0] remain_load;
  assign accept = issue_valid && issue_ready_q;
  // Accept cycle is the first instruction cycle, so load count minus one
  assign remain_load = dec_cycles - sct_pkg::CYC_ONE;

  // Counts down once per clock edge, so a cycle is one clock
  sct_cycle_counter #(
    .W(sct_pkg::CYC_W)
  ) u_remain (
    .clk(clk),
    .rstn(rstn),
    .load(accept),
    .load_value(remain_load),
    .count_d(remain_d),
    .count_q(remain_q)
  );

  // Ready reopens once nothing remains, so the next accept falls C clocks after this one
  logic ready_d;
  assign ready_d = (remain_d == '0);

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      issue_ready_q <= 1'b1;
    end else begin
      issue_ready_q <= ready_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Captured timing of the instruction in execution
  sct_hold_reg #(
    .W(sct_pkg::BYTES_W)
  ) u_bytes (
    .clk(clk),
    .rstn(rstn),
    .load(accept),
    .d(dec_bytes),
    .q(cur_bytes_q)
  );

  sct_hold_reg #(
    .W(sct_pkg::CYC_W)
  ) u_cycles (
    .clk(clk),
    .rstn(rstn),
    .load(accept),
    .d(dec_cycles),
    .q(cur_cycles_q)
  );

  // Flags travel in one holder: external move, interrupt call, miss
  logic [2:0] flags_q;
  sct_hold_reg #(
    .W(3)
  ) u_flags (
    .clk(clk),
    .rstn(rstn),
    .load(accept),
    .d({ext_move, irq_call, !dec_hit}),
    .q(flags_q)
  );
  assign cur_ext_move_q = flags_q[2];
  assign cur_irq_call_q = flags_q[1];
  assign decode_miss_q = flags_q[0];

  ////////////////////////////////////////////////////////////////////////
  // Checks: helper counter of cycles spent with ready low
  logic [sct_pkg::CYC_W-1:0] hold_run_q;
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      hold_run_q <= sct_pkg::RST_CYC;
    end else if (accept) begin
      hold_run_q <= sct_pkg::RST_CYC;
    end else if (!issue_ready_q) begin
      hold_run_q <= hold_run_q + sct_pkg::CYC_ONE;
    end
  end

  sequence s_take(logic cls);
    issue_valid && issue_ready_q && cls;
  endsequence

  sequence s_one_two;
    cur_bytes_q == 2'h1 && cur_cycles_q == 5'h02;
  endsequence

  sequence s_two_two;
    cur_bytes_q == 2'h2 && cur_cycles_q == 5'h02;
  endsequence

  sequence s_three_four;
    cur_bytes_q == 2'h3 && cur_cycles_q == 5'h04 && !issue_ready_q;
  endsequence

  // Hold-off steps: ready low for C-1 clocks, then open
  sequence s_open_two;
    !issue_ready_q ##1 issue_ready_q;
  endsequence

  sequence s_open_three;
    !issue_ready_q [*2] ##1 issue_ready_q;
  endsequence

  a_logic_reg_one: assert property (@(posedge clk) disable iff (!rstn)
    s_take(lg_reg) |=> cur_bytes_q == 2'h1 && cur_cycles_q == 5'h01 && issue_ready_q)
    else $error("register logic op not one byte one cycle");

  a_logic_ind_two: assert property (@(posedge clk) disable iff (!rstn)
    s_take(lg_ind) |=> s_one_two ##0 s_open_two)
    else $error("indirect logic op not two cycles");

  a_logic_dir_two: assert property (@(posedge clk) disable iff (!rstn)
    s_take(lg_two) |=> s_two_two)
    else $error("direct logic op not two bytes two cycles");

  a_logic_imm_three: assert property (@(posedge clk) disable iff (!rstn)
    s_take(lg_three) |=> (cur_bytes_q == 2'h3 && cur_cycles_q == 5'h03) ##0 s_open_three)
    else $error("immediate to direct logic op not three cycles");

  a_acc_single: assert property (@(posedge clk) disable iff (!rstn)
    s_take(acc_op) |=> cur_cycles_q == 5'h01 && issue_ready_q)
    else $error("accumulator op not single cycle");

  a_bit_two: assert property (@(posedge clk) disable iff (!rstn)
    s_take(bit_op || bit_move) |=> s_two_two)
    else $error("bit op not two bytes two cycles");

  a_ptr_jump_hold: assert property (@(posedge clk) disable iff (!rstn)
    s_take(br_ptr) |=> (cur_bytes_q == 2'h1 && cur_cycles_q == 5'h03) ##0 s_open_three)
    else $error("pointer jump not three cycles");

  a_rel_three: assert property (@(posedge clk) disable iff (!rstn)
    s_take(br_abs || br_rel) |=> cur_bytes_q == 2'h2 && cur_cycles_q == 5'h03)
    else $error("relative or absolute branch not two bytes three cycles");

  a_long_four: assert property (@(posedge clk) disable iff (!rstn)
    s_take(br_long && !issue_from_irq) |=> s_three_four [*3] ##1 issue_ready_q)
    else $error("long branch from code not four cycles");

  a_cond_four: assert property (@(posedge clk) disable iff (!rstn)
    s_take(br_bit || br_cmp || br_dec_dir) |=> s_three_four [*3] ##1 issue_ready_q)
    else $error("three byte branch not four cycles");

  a_ext_wait: assert property (@(posedge clk) disable iff (!rstn)
    s_take(ext_move) |=> cur_ext_move_q && cur_cycles_q == $past(ext_wait_setting) + 5'h04)
    else $error("external move cycles not four plus wait");

  a_irq_call_three: assert property (@(posedge clk) disable iff (!rstn)
    s_take(irq_call) |=> (cur_irq_call_q && cur_cycles_q == 5'h03) ##0 s_open_three)
    else $error("interrupt long call not three cycles");

  a_fetch_hold_len: assert property (@(posedge clk) disable iff (!rstn)
    $rose(issue_ready_q) |-> hold_run_q == cur_cycles_q - 5'h01)
    else $error("fetch released early or late");

  a_clock_per_cycle: assert property (@(posedge clk) disable iff (!rstn)
    !issue_ready_q |=> remain_q == $past(remain_q) - 5'h01)
    else $error("cycle counter not stepping once per clock");

  // Hold-off shape per class; held timing must stand while the fetch is refused
  a_two_hold: assert property (@(posedge clk) disable iff (!rstn)
    s_take(lg_two || bit_op || bit_move) |=> s_open_two)
    else $error("two cycle op not held for two clocks");

  a_return_four: assert property (@(posedge clk) disable iff (!rstn)
    s_take(br_return) |=> (cur_bytes_q == 2'h1 && cur_cycles_q == 5'h04 && !issue_ready_q) [*3] ##1 issue_ready_q)
    else $error("return not one byte four cycles");

  a_ext_hold: assert property (@(posedge clk) disable iff (!rstn)
    s_take(ext_move) |=> !issue_ready_q [*3])
    else $error("external move released before four clocks");

  a_miss_single: assert property (@(posedge clk) disable iff (!rstn)
    s_take(!dec_hit) |=> decode_miss_q && cur_bytes_q == 2'h1 && cur_cycles_q == 5'h01 && issue_ready_q)
    else $error("unlisted opcode not one byte one cycle");

  a_refuse_keep: assert property (@(posedge clk) disable iff (!rstn)
    !issue_ready_q |=> $stable(cur_cycles_q) && $stable(cur_bytes_q))
    else $error("held timing changed while fetch refused");

  a_hold_bound: assert property (@(posedge clk) disable iff (!rstn)
    !issue_ready_q |-> hold_run_q <= cur_cycles_q - 5'h02)
    else $error("fetch held past the cycle count");

  a_sane_values: assert property (@(posedge clk) disable iff (!rstn)
    s_take(1'h1) |=> cur_bytes_q != 2'h0 && cur_cycles_q != 5'h00)
    else $error("accepted instruction with zero length or cycles");

  a_irq_only_call: assert property (@(posedge clk) disable iff (!rstn)
    s_take(!br_call) |=> !cur_irq_call_q)
    else $error("interrupt marker kept on a non-call opcode");

endmodule

// ---- bench/sct_instr_timing_tb.sv ----
/*
  Self-checking bench for the instruction timing decoder.
  Assumes the bench alone drives the fetch side; every input changes 1 ns after a rising edge.
*/
`timescale 1ns/100ps
module sct_instr_timing_tb;
  logic clk;
  logic rstn;
  logic issue_valid;
  logic [sct_pkg::OPC_W-1:0] issue_opcode;
  logic issue_from_irq;
  logic [sct_pkg::WAIT_W-1:0] ext_wait_setting;
  logic issue_ready_q;
  logic [sct_pkg::BYTES_W-1:0] cur_bytes_q;
  logic [sct_pkg::CYC_W-1:0] cur_cycles_q;
  logic cur_ext_move_q;
  logic cur_irq_call_q;
  logic decode_miss_q;
  int mismatches;
  int checks;
  int prev_cyc;
  realtime prev_t;

  ////////////////////////////////////////////////////////////////////////
  // Clock and device
  always #2.5 clk = ~clk;

  sct_instr_timing u_dut (
    .clk(clk),
    .rstn(rstn),
    .issue_valid(issue_valid),
    .issue_opcode(issue_opcode),
    .issue_from_irq(issue_from_irq),
    .ext_wait_setting(ext_wait_setting),
    .issue_ready_q(issue_ready_q),
    .cur_bytes_q(cur_bytes_q),
    .cur_cycles_q(cur_cycles_q),
    .cur_ext_move_q(cur_ext_move_q),
    .cur_irq_call_q(cur_irq_call_q),
    .decode_miss_q(decode_miss_q)
  );

  ////////////////////////////////////////////////////////////////////////
  // Compare and closing tasks
  task automatic check_num(input string what, input logic [7:0] exp, input logic [7:0] got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %0h seen %0h", what, exp, got);
    end
  endtask

  task automatic check_flag(input string what, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("wrong value %s expected %b seen %b", what, exp, got);
    end
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Offer one opcode, hold it until taken, then judge what was decoded.
  // Valid stays high afterwards so the next call runs back to back; the
  // spacing of accept edges then shows how many clocks the last one held.
  task automatic issue(input logic [7:0] op, input logic irq, input logic [3:0] nw,
                       input logic [1:0] len, input logic [4:0] cyc, input logic ext, input logic miss);
    int n;
    realtime t;
    issue_valid = 1'h1;
    issue_opcode = op;
    issue_from_irq = irq;
    ext_wait_setting = nw;
    n = 0;
    @(negedge clk);
    while (issue_ready_q !== 1'b1) begin
      n++;
      if (n > 40) begin
        mismatches++;
        $display("wrong value ready wait expected 1 seen 0");
        stop_test();
      end
      @(negedge clk);
    end
    @(posedge clk);
    #1;
    t = $realtime;
    if (prev_cyc != 0) check_num("accept spacing", 8'(prev_cyc), 8'(int'((t - prev_t) / 5.0)));
    prev_cyc = cyc;
    prev_t = t;
    check_num("length", {6'h00, len}, {6'h00, cur_bytes_q});
    check_num("cycles", {3'h0, cyc}, {3'h0, cur_cycles_q});
    check_flag("ext move", ext, cur_ext_move_q);
    check_flag("irq call", irq && op == 8'h12, cur_irq_call_q);
    check_flag("miss", miss, decode_miss_q);
    if (cyc >= 5'h02) check_flag("ready held low", 1'h0, issue_ready_q);
  endtask

  // Drop valid and let the last instruction run out
  task automatic idle;
    issue_valid = 1'h0;
    repeat (prev_cyc + 1) @(posedge clk);
    #1;
    check_flag("ready idle", 1'h1, issue_ready_q);
    prev_cyc = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Scenarios
  task automatic test_logic;
    logic [3:0] hi[3] = '{4'h4, 4'h5, 4'h6};
    foreach (hi[i]) begin
      for (int r = 8; r < 16; r++) issue({hi[i], 4'(r)}, 1'h0, 4'h0, 2'h1, 5'h01, 1'h0, 1'h0);
      issue({hi[i], 4'h6}, 1'h0, 4'h0, 2'h1, 5'h02, 1'h0, 1'h0);
      issue({hi[i], 4'h7}, 1'h0, 4'h0, 2'h1, 5'h02, 1'h0, 1'h0);
      issue({hi[i], 4'h5}, 1'h0, 4'h0, 2'h2, 5'h02, 1'h0, 1'h0);
      issue({hi[i], 4'h4}, 1'h0, 4'h0, 2'h2, 5'h02, 1'h0, 1'h0);
      issue({hi[i], 4'h2}, 1'h0, 4'h0, 2'h2, 5'h02, 1'h0, 1'h0);
      issue({hi[i], 4'h3}, 1'h0, 4'h0, 2'h3, 5'h03, 1'h0, 1'h0);
    end
    issue(8'h00, 1'h0, 4'h0, 2'h1, 5'h01, 1'h0, 1'h0);
    idle();
  endtask

  task automatic test_acc_bit;
    logic [7:0] one[11] = '{8'hE4, 8'hF4, 8'hC4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC3, 8'hD3, 8'hB3, 8'h00};
    logic [7:0] two[9] = '{8'hC2, 8'hD2, 8'hB2, 8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2, 8'h92};
    foreach (two[i]) issue(two[i], 1'h0, 4'h0, 2'h2, 5'h02, 1'h0, 1'h0);
    foreach (one[i]) issue(one[i], 1'h0, 4'h0, 2'h1, 5'h01, 1'h0, 1'h0);
    idle();
  endtask

  task automatic test_branch;
    logic [7:0] rel[5] = '{8'h80, 8'h40, 8'h50, 8'h60, 8'h70};
    logic [7:0] far[8] = '{8'h02, 8'h12, 8'h20, 8'h30, 8'h10, 8'hB5, 8'hB4, 8'hD5};
    issue(8'h73, 1'h0, 4'h0, 2'h1, 5'h03, 1'h0, 1'h0);
    for (int h = 0; h < 16; h++) issue({4'(h), 4'h1}, 1'h0, 4'h0, 2'h2, 5'h03, 1'h0, 1'h0);
    foreach (rel[i]) issue(rel[i], 1'h0, 4'h0, 2'h2, 5'h03, 1'h0, 1'h0);
    for (int r = 8; r < 16; r++) issue({4'hD, 4'(r)}, 1'h0, 4'h0, 2'h2, 5'h03, 1'h0, 1'h0);
    foreach (far[i]) issue(far[i], 1'h0, 4'h0, 2'h3, 5'h04, 1'h0, 1'h0);
    for (int r = 6; r < 16; r++) issue({4'hB, 4'(r)}, 1'h0, 4'h0, 2'h3, 5'h04, 1'h0, 1'h0);
    issue(8'h22, 1'h0, 4'h0, 2'h1, 5'h04, 1'h0, 1'h0);
    issue(8'h32, 1'h0, 4'h0, 2'h1, 5'h04, 1'h0, 1'h0);
    issue(8'h00, 1'h0, 4'h0, 2'h1, 5'h01, 1'h0, 1'h0);
    idle();
  endtask

  // Wait states at both ends of the field, back to back
  task automatic test_ext;
    logic [7:0] op[6] = '{8'hE0, 8'hE2, 8'hE3, 8'hF0, 8'hF2, 8'hF3};
    logic [3:0] nw[6] = '{4'h0, 4'h1, 4'h5, 4'hF, 4'h7, 4'h0};
    foreach (op[i]) issue(op[i], 1'h0, nw[i], 2'h1, 5'h04 + 5'(nw[i]), 1'h1, 1'h0);
    issue(8'h00, 1'h0, 4'h0, 2'h1, 5'h01, 1'h0, 1'h0);
    idle();
  endtask

  // Interrupt-entry call is shorter; the marker is ignored elsewhere
  task automatic test_irq;
    issue(8'h12, 1'h1, 4'h0, 2'h3, 5'h03, 1'h0, 1'h0);
    issue(8'h12, 1'h0, 4'h0, 2'h3, 5'h04, 1'h0, 1'h0);
    issue(8'h12, 1'h1, 4'h0, 2'h3, 5'h03, 1'h0, 1'h0);
    issue(8'h02, 1'h1, 4'h0, 2'h3, 5'h04, 1'h0, 1'h0);
    issue(8'h24, 1'h0, 4'h0, 2'h1, 5'h01, 1'h0, 1'h1);
    issue(8'h00, 1'h0, 4'h0, 2'h1, 5'h01, 1'h0, 1'h0);
    idle();
  endtask

  // Reset in the middle of a long external move
  task automatic test_mid_reset;
    issue(8'hE0, 1'h0, 4'hF, 2'h1, 5'h13, 1'h1, 1'h0);
    issue_valid = 1'h0;
    @(posedge clk);
    #1;
    rstn = 1'h0;
    #1;
    check_flag("ready in reset", 1'h1, issue_ready_q);
    check_num("cycles in reset", 8'h00, {3'h0, cur_cycles_q});
    check_flag("ext in reset", 1'h0, cur_ext_move_q);
    @(posedge clk);
    #1;
    rstn = 1'h1;
    prev_cyc = 0;
    issue(8'h58, 1'h0, 4'h0, 2'h1, 5'h01, 1'h0, 1'h0);
    issue(8'h00, 1'h0, 4'h0, 2'h1, 5'h01, 1'h0, 1'h0);
    idle();
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    clk = 1'h0;
    rstn = 1'h0;
    issue_valid = 1'h0;
    issue_opcode = 8'h00;
    issue_from_irq = 1'h0;
    ext_wait_setting = 4'h0;
    mismatches = 0;
    checks = 0;
    prev_cyc = 0;
    prev_t = 0;
    repeat (20) @(posedge clk);
    #1;
    check_flag("ready in reset", 1'h1, issue_ready_q);
    check_num("length in reset", 8'h00, {6'h00, cur_bytes_q});
    check_flag("miss in reset", 1'h0, decode_miss_q);
    rstn = 1'h1;
    test_logic();
    test_acc_bit();
    test_branch();
    test_ext();
    test_irq();
    test_mid_reset();
    stop_test();
  end
endmodule
